/* File: hdl/tcb_defines.svh */
// Register offsets, field positions and reset values of the timer block.
`ifndef TCB_DEFINES_SVH
`define TCB_DEFINES_SVH
`define TCB_OFS_CTRLB 8'h00
`define TCB_OFS_CTRLA 8'h04
`define TCB_OFS_STS 8'h08
`define TCB_OFS_MSK 8'h0c
`define TCB_OFS_CNT 8'h10
`define TCB_OFS_CAP1 8'h14
`define TCB_OFS_CAP2 8'h18
`define TCB_OFS_DUTY 8'h1c
`define TCB_OFS_PORT0 8'h20
`define TCB_BIT_PORT_SRC 7
`define TCB_BIT_CAP_EDGE 6
`define TCB_BIT_EVT_EDGE 5
`define TCB_PSC_HI 4
`define TCB_PSC_LO 2
`define TCB_MODE_HI 1
`define TCB_MODE_LO 0
`define TCB_BIT_OVIE 0
`define TCB_STS_OVF 0
`define TCB_STS_CAP1 1
`define TCB_STS_CAP2 2
`define TCB_CTRLB_RST 8'h00
`define TCB_CTRLA_RST 8'h00
`define TCB_STS_RST 3'h0
`define TCB_MSK_RST 3'h0
`define TCB_CNT_RST 16'h0000
`define TCB_CNT_TOP 16'hffff
`endif

/* File: hdl/tcb_pkg.sv */
// Types shared by the timer control block modules.
package tcb_pkg;
  // Operating modes held in the two-bit mode field.
  typedef enum logic [1:0] {
    TCB_MODE_SW  = 2'b00,
    TCB_MODE_PWM = 2'b01,
    TCB_MODE_CAP = 2'b10,
    TCB_MODE_EVT = 2'b11
  } tcb_mode_t;
endpackage

/* File: hdl/tcb_evt_if.sv */
// Interface between the timer core, its edge detector and its prescaler.
`timescale 1ns/1ps
interface tcb_evt_if;
  logic [2:0] pins;     // Raw capture 1, capture 2 and event pins.
  logic cap_rise;       // Capture pins sense rising edges when high.
  logic evt_rise;       // Event pin senses rising edges when high.
  logic [2:0] edges;    // One-cycle pulses for each selected edge.
  logic [2:0] psc_code; // Power-of-two prescaler code.
  logic tick;           // One-cycle pulse per prescaled period.
  modport core(output pins, output cap_rise, output evt_rise,
    output psc_code, input edges, input tick);
  modport edge_det(input pins, input cap_rise, input evt_rise,
    output edges);
  modport psc(input psc_code, output tick);
endinterface

/* File: hdl/tcb_edge_det.sv */
// Synchroniser and polarity-selectable edge detector for timer pins.
`timescale 1ns/1ps
module tcb_edge_det
  import tcb_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  tcb_evt_if.edge_det ev
);
  logic [2:0] s1_r;   // First synchroniser stage, read only by s2_r.
  logic [2:0] s2_r;   // Second synchroniser stage.
  logic [2:0] s3_r;   // Previous synchronised level for edge compare.
  logic [2:0] edg_r;  // Registered edge pulses.
  logic [2:0] vld_r;  // Ones shift in; compares wait for real pin levels.

  // Pins pass two flops before any compare sees them.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      s3_r <= 3'h0;
    end else begin
      s1_r <= ev.pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Edges stay quiet until the third stage holds a real pin level, so a
  // pin that idles high makes no false edge after reset.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      vld_r <= 3'h0;
    end else begin
      vld_r <= {vld_r[1:0], 1'b1};
    end
  end

  // The event pin picks its own polarity; both capture pins share one.
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_edge
      logic rise;
      assign rise = (i < 2) ? ev.cap_rise : ev.evt_rise;
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          edg_r[i] <= 1'b0;
        end else begin
          edg_r[i] <= vld_r[2] & (rise ? (s2_r[i] & ~s3_r[i])
                                       : (~s2_r[i] & s3_r[i]));
        end
      end
    end
  endgenerate

  assign ev.edges = edg_r;
endmodule

/* File: hdl/tcb_prescaler.sv */
// Power-of-two divider that yields the timer tick from the system clock.
`timescale 1ns/1ps
module tcb_prescaler
  import tcb_pkg::*;
#(
  parameter int DIV_W = 7
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  tcb_evt_if.psc ev
);
  logic [DIV_W-1:0] div_r;  // Free-running divider count.
  logic [DIV_W-1:0] mask;   // Low bits that must all be ones for a tick.
  logic tick_r;             // Registered tick pulse.

  // Mask holds code ones, so the tick repeats every 2**code clocks.
  assign mask = DIV_W'((8'h01 << ev.psc_code) - 8'h01);

  // Divider runs on every clock; a tick falls when the masked bits wrap.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_r + DIV_W'(1);
      tick_r <= &(div_r | ~mask);
    end
  end

  assign ev.tick = tick_r;
endmodule

/* File: hdl/tcb_timer2_ctrl.sv */
// Timer two control register block with Avalon-MM slave and port reads.
`timescale 1ns/1ps
`include "tcb_defines.svh"
module tcb_timer2_ctrl
  import tcb_pkg::*;
#(
  parameter int N_PORTS = 5,
  parameter int PORT_W = 8
)
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [7:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  input wire logic [1:0] CAPTURE_PIN_IN,
  input wire logic EVENT_PIN_IN,
  input wire logic [N_PORTS*PORT_W-1:0] PORT_PIN_IN,
  output logic [N_PORTS*PORT_W-1:0] PORT_DATA_OUT,
  output logic PWM_OUT,
  output logic IRQ_OUT
);
  // Internal carrier to the edge detector and the prescaler.
  tcb_evt_if ev ();

  logic [7:0] timer2_control_b_r; // Control B register, all fields.
  logic [7:0] ctrla_r;       // Control A register, overflow enable.
  logic [2:0] sts_r;         // Sticky event status.
  logic [2:0] msk_r;         // Interrupt mask.
  logic [15:0] cnt_r;        // Timer counter.
  logic [15:0] cap1_r;       // Capture 1 value.
  logic [15:0] cap2_r;       // Capture 2 value.
  logic [15:0] duty_r;       // PWM threshold.
  logic [PORT_W-1:0] pdat_r [N_PORTS]; // Port output data registers.
  logic [PORT_W-1:0] ps1_r [N_PORTS];  // Port pin first sync stage.
  logic [PORT_W-1:0] ps2_r [N_PORTS];  // Port pin second sync stage.
  logic wait_r;              // Waitrequest flop.
  logic [31:0] rdata_r;      // Read data flop.
  logic [31:0] rd_nxt;       // Read data next value.
  logic pwm_r;               // PWM output flop.
  logic irq_r;               // Interrupt output flop.
  logic req;                 // A request is present.
  logic acc;                 // Request accepted at this edge.
  logic wr;                  // Write takes effect at this edge.
  logic [7:0] wa;            // Word-aligned address.
  logic [2:0] sts_set;       // Hardware status set pulses.
  logic [2:0] sts_clr;       // Software write-one-to-clear bits.
  logic inc;                 // Counter increment pulse.
  logic ovf;                 // Counter overflow pulse.
  tcb_mode_t mode;           // Current operating mode.
  logic port_read_source_sel; // Port reads show data registers when high.
  logic tmr2_capture_edge_sel; // Capture pins sense rising edges when high.
  logic tmr2_event_edge_sel; // Event pin senses rising edges when high.
  logic [2:0] tmr2_prescale_code; // Power-of-two prescaler code.
  logic [1:0] tmr2_mode_code; // Raw two-bit mode field.
  logic tmr2_overflow_irq_en; // Overflow interrupt enable from control A.
  logic [PORT_W-1:0] pview [N_PORTS]; // What a read of each port shows.

  // Register map, byte offsets; address bits 1:0 are ignored.
  // 0x00 control B: port read source, edge senses, prescaler, mode.
  // 0x04 control A: bit 0 enables the overflow interrupt.
  // 0x08 status: overflow, capture 1, capture 2; write one to clear.
  // 0x0c mask: same layout as status, a one lets the bit interrupt.
  // 0x10 counter, 16 bits, writable by software.
  // 0x14 and 0x18 capture 1 and capture 2 values, read only.
  // 0x1c PWM threshold, 16 bits.
  // 0x20 plus four per port: that port's output data register.
  // Any other word reads as zero and ignores writes.

  // Bus decode: one request is taken per two-cycle access.
  assign wa = {AVS_ADDRESS_IN[7:2], 2'b00};
  assign req = AVS_READ_IN | AVS_WRITE_IN;
  assign acc = req & ~wait_r;
  assign wr = acc & AVS_WRITE_IN;

  // Control B fields, unpacked once so the rest of the block reads names.
  // Every field is a plain wire from the register, so a write acts on
  // the very next clock without any extra staging.
  assign port_read_source_sel = timer2_control_b_r[`TCB_BIT_PORT_SRC];
  assign tmr2_capture_edge_sel = timer2_control_b_r[`TCB_BIT_CAP_EDGE];
  assign tmr2_event_edge_sel = timer2_control_b_r[`TCB_BIT_EVT_EDGE];
  assign tmr2_prescale_code = timer2_control_b_r[`TCB_PSC_HI:`TCB_PSC_LO];
  assign tmr2_mode_code = timer2_control_b_r[`TCB_MODE_HI:`TCB_MODE_LO];
  assign tmr2_overflow_irq_en = ctrla_r[`TCB_BIT_OVIE];

  // Mode decoded straight from the control field.
  assign mode = tcb_mode_t'(tmr2_mode_code);

  // Configuration bits feed the helpers on the next clock.
  assign ev.pins = {EVENT_PIN_IN, CAPTURE_PIN_IN};
  assign ev.cap_rise = tmr2_capture_edge_sel;
  assign ev.evt_rise = tmr2_event_edge_sel;
  assign ev.psc_code = tmr2_prescale_code;

  // Edge detector for capture and event pins.
  tcb_edge_det u_edge (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .ev(ev.edge_det)
  );

  // Prescaler giving the timer tick.
  tcb_prescaler u_psc (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .ev(ev.psc)
  );

  // Waitrequest drops for one cycle after a request, then rises again.
  // A request seen with waitrequest high opens the access; the edge after
  // that, with waitrequest low, is where a write lands and the master
  // takes read data. Every access costs two cycles, even back to back,
  // and the master needs no count of its own: it watches this flop.
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wait_r <= 1'b1;
    end else if (req && wait_r) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  // Read data are latched as waitrequest falls and held afterwards.
  // The value handed over is the one that stood when the request was
  // first seen, and it stands until the next read replaces it.
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdata_r <= 32'h0000_0000;
    end else if (AVS_READ_IN && wait_r) begin
      rdata_r <= rd_nxt;
    end
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (wa)
      `TCB_OFS_CTRLB: rd_nxt[7:0] = timer2_control_b_r;
      `TCB_OFS_CTRLA: rd_nxt[7:0] = ctrla_r;
      `TCB_OFS_STS: rd_nxt[2:0] = sts_r;
      `TCB_OFS_MSK: rd_nxt[2:0] = msk_r;
      `TCB_OFS_CNT: rd_nxt[15:0] = cnt_r;
      `TCB_OFS_CAP1: rd_nxt[15:0] = cap1_r;
      `TCB_OFS_CAP2: rd_nxt[15:0] = cap2_r;
      `TCB_OFS_DUTY: rd_nxt[15:0] = duty_r;
      default: begin
        // Port window: each port's view was already picked per port.
        for (int p = 0; p < N_PORTS; p++) begin
          if (wa == 8'(`TCB_OFS_PORT0 + 4 * p)) begin
            rd_nxt[PORT_W-1:0] = pview[p];
          end
        end
      end
    endcase
  end

  // Control B written from byte lane 0; all fields act next clock.
  // The port read source bit shares this byte with the timer fields but
  // steers only the port read path; nothing in the timer looks at it.
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      // Reset leaves pins as the port read source and the timer in
      // software mode with no prescaling.
      timer2_control_b_r <= `TCB_CTRLB_RST;
    end else if (wr && wa == `TCB_OFS_CTRLB && AVS_BYTEENABLE_IN[0]) begin
      timer2_control_b_r <= AVS_WRITEDATA_IN[7:0];
    end
  end

  // Control A holds the overflow interrupt enable.
  // Only bit 0 acts; the other bits are kept so software reads back what
  // it wrote.
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrla_r <= `TCB_CTRLA_RST;
    end else if (wr && wa == `TCB_OFS_CTRLA && AVS_BYTEENABLE_IN[0]) begin
      ctrla_r <= AVS_WRITEDATA_IN[7:0];
    end
  end

  // Mask register gates status bits onto the interrupt.
  // A masked bit still sets in status, so polling keeps working.
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      msk_r <= `TCB_MSK_RST;
    end else if (wr && wa == `TCB_OFS_MSK && AVS_BYTEENABLE_IN[0]) begin
      msk_r <= AVS_WRITEDATA_IN[2:0];
    end
  end

  // PWM threshold register, two byte lanes.
  // A byte written alone leaves the other byte as it was.
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      duty_r <= `TCB_CNT_RST;
    end else if (wr && wa == `TCB_OFS_DUTY) begin
      if (AVS_BYTEENABLE_IN[0]) begin
        duty_r[7:0] <= AVS_WRITEDATA_IN[7:0];
      end
      if (AVS_BYTEENABLE_IN[1]) begin
        duty_r[15:8] <= AVS_WRITEDATA_IN[15:8];
      end
    end
  end

  // Per-port data registers and pin synchronisers.
  genvar g;
  generate
    for (g = 0; g < N_PORTS; g++) begin : g_port
      // Data register written at its own word; drives the port pins.
      always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          pdat_r[g] <= '0;
        end else if (wr && AVS_BYTEENABLE_IN[0] &&
                     wa == 8'(`TCB_OFS_PORT0 + 4 * g)) begin
          pdat_r[g] <= AVS_WRITEDATA_IN[PORT_W-1:0];
        end
      end
      // Pin levels pass two flops before the read mux sees them.
      // Reads thus show the pins two clocks late, never a metastable bit.
      always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          ps1_r[g] <= '0;
          ps2_r[g] <= '0;
        end else begin
          ps1_r[g] <= PORT_PIN_IN[g*PORT_W +: PORT_W];
          ps2_r[g] <= ps1_r[g];
        end
      end
      assign PORT_DATA_OUT[g*PORT_W +: PORT_W] = pdat_r[g];
      // Read view: data register or synchronised pins, chosen per port
      // by the one shared source bit, so all ports follow it alike.
      assign pview[g] = port_read_source_sel
        ? pdat_r[g] : ps2_r[g];
    end
  endgenerate

  // Event mode counts pin edges; other modes count prescaled ticks.
  // The prescaler runs free and is not restarted when its code changes,
  // so the first tick after a change may come early.
  assign inc = (mode == TCB_MODE_EVT) ? ev.edges[2] : ev.tick;
  assign ovf = inc && (cnt_r == `TCB_CNT_TOP);

  // Counter: a software write wins over an increment in the same cycle.
  // That tick is lost, which keeps a written value exactly as written.
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cnt_r <= `TCB_CNT_RST;
    end else if (wr && wa == `TCB_OFS_CNT) begin
      if (AVS_BYTEENABLE_IN[0]) begin
        cnt_r[7:0] <= AVS_WRITEDATA_IN[7:0];
      end
      if (AVS_BYTEENABLE_IN[1]) begin
        cnt_r[15:8] <= AVS_WRITEDATA_IN[15:8];
      end
    end else if (inc) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // Capture registers load the count on a selected edge in capture mode.
  // Outside that mode the pins are ignored and the last values stay.
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cap1_r <= `TCB_CNT_RST;
      cap2_r <= `TCB_CNT_RST;
    end else if (mode == TCB_MODE_CAP) begin
      if (ev.edges[0]) begin
        cap1_r <= cnt_r;
      end
      if (ev.edges[1]) begin
        cap2_r <= cnt_r;
      end
    end
  end

  // Events that set sticky status bits.
  assign sts_set[`TCB_STS_OVF] = ovf;
  assign sts_set[`TCB_STS_CAP1] = (mode == TCB_MODE_CAP) & ev.edges[0];
  assign sts_set[`TCB_STS_CAP2] = (mode == TCB_MODE_CAP) & ev.edges[1];
  assign sts_clr = (wr && wa == `TCB_OFS_STS && AVS_BYTEENABLE_IN[0])
    ? AVS_WRITEDATA_IN[2:0] : 3'h0;

  // Status: write one to clear, and a new event wins over the clear.
  // An event in the cycle of its clear is therefore never lost.
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sts_r <= `TCB_STS_RST;
    end else begin
      sts_r <= (sts_r & ~sts_clr) | sts_set;
    end
  end

  // Interrupt level; overflow also needs its enable bit.
  // The output is a level and falls once software clears the status bit.
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(sts_r & msk_r &
        {2'b11, tmr2_overflow_irq_en});
    end
  end

  // In PWM mode the output is high while the count is below the threshold; in other modes it stays low.
  // A threshold of zero keeps the output low for the whole period.
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pwm_r <= 1'b0;
    end else begin
      pwm_r <= (mode == TCB_MODE_PWM) && (cnt_r < duty_r);
    end
  end

  // Every output is the plain value of a flop.
  assign AVS_READDATA_OUT = rdata_r;
  assign AVS_WAITREQUEST_OUT = wait_r;
  assign PWM_OUT = pwm_r;
  assign IRQ_OUT = irq_r;
endmodule

/* File: testbench/tcb_pin_model.sv */
// Behavioural model of the capture and event pins outside the timer.
`timescale 1ns/1ps
module tcb_pin_model (
  input wire logic [2:0] lvl_in,
  output logic [1:0] cap_out,
  output logic evt_out
);
  // The pins follow the levels asked for, with no glitches between.
  assign cap_out = lvl_in[1:0];
  assign evt_out = lvl_in[2];
endmodule

/* File: testbench/tcb_ctrl_props.sv */
// Port-level assertions for the timer two control block.
`timescale 1ns/1ps
module tcb_ctrl_props
  import tcb_pkg::*;
#(
  parameter int N_PORTS = 5,
  parameter int PORT_W = 8
)
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [7:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic AVS_WAITREQUEST_OUT,
  input wire logic [N_PORTS*PORT_W-1:0] PORT_DATA_OUT,
  input wire logic PWM_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  logic [7:0] ctrl_r; // Shadow copy of control B.
  logic wr_done; // A write completes at this edge.
  logic rd_done; // A read completes at this edge.
  assign wr_done = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;
  assign rd_done = AVS_READ_IN && !AVS_WAITREQUEST_OUT;
  // The shadow follows every completed write to control B.
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl_r <= 8'h00;
    end else if (wr_done && AVS_ADDRESS_IN[7:2] == 6'h00) begin
      ctrl_r <= AVS_WRITEDATA_IN[7:0];
    end
  end
  property p_ans;
    (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=>
      !AVS_WAITREQUEST_OUT;
  endproperty
  a_ans: assert property (p_ans) else $error("no bus answer");
  property p_idle;
    !(AVS_READ_IN || AVS_WRITE_IN) |=> AVS_WAITREQUEST_OUT;
  endproperty
  a_idle: assert property (p_idle) else $error("idle answer");
  property p_rdbk;
    rd_done && AVS_ADDRESS_IN == 8'h00 |-> AVS_READDATA_OUT[7:0] == ctrl_r;
  endproperty
  a_rdbk: assert property (p_rdbk) else $error("readback");
  property p_unmap;
    rd_done && AVS_ADDRESS_IN == 8'h34 |-> AVS_READDATA_OUT == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_pwr;
    wr_done && AVS_ADDRESS_IN == 8'h20 |=>
      PORT_DATA_OUT[7:0] == $past(AVS_WRITEDATA_IN[7:0]);
  endproperty
  a_pwr: assert property (p_pwr) else $error("port data write");
  property p_prd;
    rd_done && AVS_ADDRESS_IN == 8'h30 && ctrl_r[7] |->
      AVS_READDATA_OUT[7:0] == PORT_DATA_OUT[39:32];
  endproperty
  a_prd: assert property (p_prd) else $error("port register read");
  property p_stand;
    $changed(AVS_READDATA_OUT) |->
      $past(AVS_READ_IN && AVS_WAITREQUEST_OUT);
  endproperty
  a_stand: assert property (p_stand) else $error("read data moved");
  property p_pwm;
    ctrl_r[1:0] != TCB_MODE_PWM && $past(ctrl_r[1:0]) != TCB_MODE_PWM
      |-> !PWM_OUT;
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm outside mode");
endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the timer two control block.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module tb;
  import tcb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, got;
  logic wt, pwm, irq, evt;
  logic [1:0] cap;
  logic [2:0] lvl = 3'h0; // Levels asked of the pin model.
  logic [39:0] pins = 40'h5a_11_22_33_a5; // Port pin levels.
  logic [39:0] pdat;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int t1;
  tcb_timer2_ctrl u_tcb_timer2_ctrl (.CLK_IN(clk), .RST_IN(rst),
    .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
    .AVS_WRITEDATA_IN(wdat), .AVS_BYTEENABLE_IN(4'hf),
    .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wt),
    .CAPTURE_PIN_IN(cap), .EVENT_PIN_IN(evt), .PORT_PIN_IN(pins),
    .PORT_DATA_OUT(pdat), .PWM_OUT(pwm), .IRQ_OUT(irq));
  tcb_pin_model u_tcb_pin_model (.lvl_in(lvl), .cap_out(cap),
    .evt_out(evt));
  // The clock toggles every 50 ns, a period of 100 ns.
  initial begin
    forever #50 clk = ~clk;
  end
  // Counting cycles also cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One bus access, held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    @(posedge clk);
    while (wt !== 1'b0) @(posedge clk);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic t_ctrl();
    logic [7:0] v;
    for (int m = 0; m < 4; m++) begin
      v = {1'b0, m[0], m[1], 3'(m + 1), m[1:0]};
      bus(1'b1, 8'h00, {24'h0, v});
      bus(1'b0, 8'h00, 32'h0);
      `CHK(got[7:0], v)
    end
    bus(1'b1, 8'h34, 32'hff);
    bus(1'b0, 8'h34, 32'h0);
    `CHK(got, 32'h0)
    $display("test ctrl done");
  endtask
  task automatic t_port();
    bus(1'b1, 8'h20, 32'h3c);
    bus(1'b1, 8'h30, 32'hc3);
    bus(1'b1, 8'h00, 32'h00);
    bus(1'b0, 8'h20, 32'h0);
    `CHK(got[7:0], pins[7:0])
    bus(1'b0, 8'h30, 32'h0);
    `CHK(got[7:0], pins[39:32])
    bus(1'b1, 8'h00, 32'h80);
    bus(1'b0, 8'h20, 32'h0);
    `CHK(got[7:0], 8'h3c)
    bus(1'b0, 8'h30, 32'h0);
    `CHK(got[7:0], 8'hc3)
    `CHK(pdat, 40'hc3_00_00_00_3c)
    $display("test port done");
  endtask
  task automatic t_psc();
    logic [15:0] c1;
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, 8'h00, {27'h0, 3'(k * k * 2 - k), 2'b00});
      bus(1'b0, 8'h10, 32'h0);
      c1 = got[15:0];
      t1 = cyc;
      repeat (253) @(posedge clk);
      bus(1'b0, 8'h10, 32'h0);
      `CHK(got[15:0], 16'(c1 + ((cyc - t1) >> (k * k * 2 - k))))
    end
    $display("test prescale done");
  endtask
  task automatic t_evt();
    bus(1'b1, 8'h00, 32'h23);
    bus(1'b1, 8'h10, 32'h0);
    repeat (3) begin
      lvl[2] <= 1'b1;
      repeat (5) @(posedge clk);
      lvl[2] <= 1'b0;
      repeat (5) @(posedge clk);
    end
    bus(1'b0, 8'h10, 32'h0);
    `CHK(got[15:0], 16'h0003)
    bus(1'b1, 8'h00, 32'h03);
    bus(1'b1, 8'h10, 32'h0);
    lvl[2] <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1'b0, 8'h10, 32'h0);
    `CHK(got[15:0], 16'h0000)
    lvl[2] <= 1'b0;
    repeat (8) @(posedge clk);
    bus(1'b0, 8'h10, 32'h0);
    `CHK(got[15:0], 16'h0001)
    $display("test event done");
  endtask
  task automatic t_cap();
    bus(1'b1, 8'h00, 32'h42);
    bus(1'b1, 8'h0c, 32'h6);
    bus(1'b1, 8'h08, 32'h7);
    lvl[0] <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1'b0, 8'h08, 32'h0);
    `CHK({got[2:0], irq}, 4'h5)
    bus(1'b1, 8'h08, 32'h2);
    bus(1'b1, 8'h00, 32'h02);
    lvl[1] <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1'b0, 8'h08, 32'h0);
    `CHK({got[2:0], irq}, 4'h0)
    lvl[1] <= 1'b0;
    repeat (8) @(posedge clk);
    bus(1'b0, 8'h08, 32'h0);
    `CHK({got[2:0], irq}, 4'h9)
    bus(1'b1, 8'h0c, 32'h0);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    bus(1'b1, 8'h08, 32'h7);
    $display("test capture done");
  endtask
  task automatic t_ovf();
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h0c, 32'h1);
    bus(1'b1, 8'h10, 32'hfff0);
    repeat (40) @(posedge clk);
    bus(1'b0, 8'h08, 32'h0);
    `CHK({got[0], irq}, 2'b10)
    bus(1'b1, 8'h04, 32'h1);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b1)
    bus(1'b1, 8'h08, 32'h1);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    $display("test overflow done");
  endtask
  task automatic t_pwm();
    bus(1'b1, 8'h1c, 32'hffff);
    bus(1'b1, 8'h00, 32'h01);
    bus(1'b1, 8'h10, 32'h0);
    repeat (3) @(posedge clk);
    `CHK(pwm, 1'b1)
    bus(1'b1, 8'h00, 32'h00);
    repeat (3) @(posedge clk);
    `CHK(pwm, 1'b0)
    bus(1'b1, 8'h1c, 32'h0);
    bus(1'b1, 8'h00, 32'h01);
    repeat (3) @(posedge clk);
    `CHK(pwm, 1'b0)
    $display("test pwm done");
  endtask
  // Main sequence: reset, then every scenario in turn.
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_ctrl();
    t_port();
    t_psc();
    t_evt();
    t_cap();
    t_ovf();
    t_pwm();
    give_verdict();
  end
endmodule
bind tcb_timer2_ctrl tcb_ctrl_props #(.N_PORTS(N_PORTS), .PORT_W(PORT_W))
  u_tcb_ctrl_props (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN),
  .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
  .AVS_READDATA_OUT(AVS_READDATA_OUT),
  .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
  .PORT_DATA_OUT(PORT_DATA_OUT), .PWM_OUT(PWM_OUT));
